// File: hdl/fru_pkg.sv
package fru_pkg;

   // Data path and file geometry
   localparam int DATA_W = 8;
   localparam int ADDR_W = 5;

   // Destination select values
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_REG = 1'b1;

   // Constants of the data path
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 5'h00;

   // Operation codes
   typedef enum logic [2:0] {
      FRU_OP_COMPLEMENT_REG = 3'b000,
      FRU_OP_DECREMENT_REG = 3'b001,
      FRU_OP_INCREMENT_REG = 3'b010,
      FRU_OP_DECREMENT_SKIP_ZERO = 3'b011,
      FRU_OP_INCREMENT_SKIP_ZERO = 3'b100
   } fru_op_e;

   // Request from the decoder
   typedef struct packed {
      fru_op_e op;
      logic [ADDR_W-1:0] addr;
      logic dest;
      logic [DATA_W-1:0] operand;
   } fru_req_s;

   // Result toward the core
   typedef struct packed {
      logic acc_we;
      logic reg_we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic zero_we;
      logic zero;
      logic skip;
   } fru_res_s;

endpackage

// File: hdl/fru_unary_ops.sv
`timescale 1ns/1ps
// Functional notes
// - Complement inverts every bit of the selected register, writes the destination, updates zero.
// - Destination bit 0 writes the accumulator, 1 writes back into the source register.
// - Decrement subtracts one, writes the destination and updates zero from the result.
// - Increment adds one, writes the destination and updates zero from the sum.
// - Decrement-and-skip subtracts one, writes the destination and leaves all flags alone.
// - A zero decrement-and-skip result discards the fetched instruction, making two cycles.
// - Increment-and-skip adds one, leaves flags alone, and skips on a zero result.
module fru_unary_ops
   import fru_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Request from decoder
   input wire logic req_valid_i,
   input wire fru_req_s req_i,
   // Result toward accumulator, file and fetch pipeline
   output fru_res_s res_o
);

   // Operation decode flags
   logic op_complement;
   logic op_decrement;
   logic op_increment;
   logic op_decrement_skip;
   logic op_increment_skip;
   logic op_sets_zero;
   logic op_skips;

   // Operand and candidate results
   logic [DATA_W-1:0] operand;
   logic [DATA_W-1:0] complement_value;
   logic [DATA_W-1:0] decrement_value;
   logic [DATA_W-1:0] increment_value;
   logic [DATA_W-1:0] result_value;
   logic result_is_zero;

   // Result data and target address state
   logic [DATA_W-1:0] data_d;
   logic [DATA_W-1:0] data_q;
   logic [ADDR_W-1:0] addr_d;
   logic [ADDR_W-1:0] addr_q;

   // Destination write enable state
   logic acc_we_d;
   logic acc_we_q;
   logic reg_we_d;
   logic reg_we_q;

   // Zero flag update state
   logic zero_we_d;
   logic zero_we_q;
   logic zero_d;
   logic zero_q;

   // Skip request state
   logic skip_d;
   logic skip_q;

   // One flag per supported operation
   always_comb begin
      op_complement = '0;
      op_decrement = '0;
      op_increment = '0;
      op_decrement_skip = '0;
      op_increment_skip = '0;
      case (req_i.op)
         FRU_OP_COMPLEMENT_REG: begin
            op_complement = '1;
         end
         FRU_OP_DECREMENT_REG: begin
            op_decrement = '1;
         end
         FRU_OP_INCREMENT_REG: begin
            op_increment = '1;
         end
         FRU_OP_DECREMENT_SKIP_ZERO: begin
            op_decrement_skip = '1;
         end
         FRU_OP_INCREMENT_SKIP_ZERO: begin
            op_increment_skip = '1;
         end
         default: begin
            // Unknown codes raise no flag
         end
      endcase
   end

   // Flag-touching and skipping classes
   assign op_sets_zero = op_complement | op_decrement | op_increment;
   assign op_skips = op_decrement_skip | op_increment_skip;

   // Current content of the selected register
   assign operand = req_i.operand;

   // Bitwise inversion, one slice per data bit
   for (genvar bit_idx = 0; bit_idx < DATA_W; bit_idx++) begin : g_invert
      assign complement_value[bit_idx] = ~operand[bit_idx];
   end

   // Carry and borrow dropped, so both wrap modulo 256
   assign decrement_value = operand - DATA_ONE;
   assign increment_value = operand + DATA_ONE;

   // Result select by operation
   always_comb begin
      result_value = DATA_ZERO;
      case (req_i.op)
         FRU_OP_COMPLEMENT_REG: begin
            result_value = complement_value;
         end
         FRU_OP_DECREMENT_REG: begin
            result_value = decrement_value;
         end
         FRU_OP_INCREMENT_REG: begin
            result_value = increment_value;
         end
         FRU_OP_DECREMENT_SKIP_ZERO: begin
            result_value = decrement_value;
         end
         FRU_OP_INCREMENT_SKIP_ZERO: begin
            result_value = increment_value;
         end
         default: begin
            // Unknown codes yield zero data
            result_value = DATA_ZERO;
         end
      endcase
   end

   // Zero detect on the selected result
   assign result_is_zero = (result_value == DATA_ZERO);

   // Next result data and target address
   always_comb begin
      data_d = DATA_ZERO;
      addr_d = ADDR_ZERO;
      if (req_valid_i) begin
         data_d = result_value;
         addr_d = req_i.addr;
      end
   end

   // Result data and address registers
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         data_q <= DATA_ZERO;
         addr_q <= ADDR_ZERO;
      end else begin
         data_q <= data_d;
         addr_q <= addr_d;
      end
   end

   // Next destination write enables
   always_comb begin
      acc_we_d = '0;
      reg_we_d = '0;
      if (req_valid_i) begin
         acc_we_d = (req_i.dest == DEST_ACC);
         reg_we_d = (req_i.dest == DEST_REG);
      end
   end

   // Destination write enable registers
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         acc_we_q <= '0;
         reg_we_q <= '0;
      end else begin
         acc_we_q <= acc_we_d;
         reg_we_q <= reg_we_d;
      end
   end

   // Next zero flag update, skip operations leave it alone
   always_comb begin
      zero_we_d = '0;
      zero_d = '0;
      if (req_valid_i) begin
         zero_we_d = op_sets_zero;
         zero_d = result_is_zero;
      end
   end

   // Zero flag update registers
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         zero_we_q <= '0;
         zero_q <= '0;
      end else begin
         zero_we_q <= zero_we_d;
         zero_q <= zero_d;
      end
   end

   // Next skip request, only a zero result of a skip operation
   always_comb begin
      skip_d = '0;
      if (req_valid_i && op_skips) begin
         skip_d = result_is_zero;
      end
   end

   // Skip request register
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         skip_q <= '0;
      end else begin
         skip_q <= skip_d;
      end
   end

   // Output bundle taken straight from the registers
   assign res_o = '{
      acc_we: acc_we_q,
      reg_we: reg_we_q,
      addr: addr_q,
      data: data_q,
      zero_we: zero_we_q,
      zero: zero_q,
      skip: skip_q
   };

endmodule

// File: tb/fru_unary_ops_asserts.sv
`timescale 1ns/1ps
module fru_unary_ops_asserts import fru_pkg::*; (input wire logic mclk_i, rst_i, req_valid_i,
input wire fru_req_s req_i, input wire fru_res_s res_o);
logic v_q;
fru_req_s p_q;
wire [7:0] d = p_q.operand, x = res_o.data;
wire [2:0] o = p_q.op;
wire z = res_o.zero_we;
// Request taken one edge back
always_ff @(posedge mclk_i) begin
v_q <= req_valid_i & ~rst_i;
p_q <= req_i;
end
default clocking @(posedge mclk_i); endclocking
default disable iff (rst_i);
property p_1; v_q && o==0 |-> x==~d && z; endproperty
a_1: assert property (p_1) else $error("a1");
property p_2; v_q && o<5 |-> res_o.reg_we==p_q.dest && res_o.acc_we!=p_q.dest; endproperty
a_2: assert property (p_2) else $error("a2");
property p_3; v_q && o==1 |-> x==d-DATA_ONE && z && res_o.zero==(x==0); endproperty
a_3: assert property (p_3) else $error("a3");
property p_4; v_q && o==2 |-> x==d+DATA_ONE && z && res_o.zero==(x==0); endproperty
a_4: assert property (p_4) else $error("a4");
property p_5; v_q && o==3 |-> x==d-DATA_ONE && !z; endproperty
a_5: assert property (p_5) else $error("a5");
property p_6; v_q && o==3 |-> res_o.skip==(d==1); endproperty
a_6: assert property (p_6) else $error("a6");
property p_7; v_q && o==4 |-> x==d+DATA_ONE && !z && res_o.skip==(d==8'hff); endproperty
a_7: assert property (p_7) else $error("a7");
property p_8; v_q && o<5 && (o[0] ? d==0 : o!=0 && d==8'hff) |-> x==~d; endproperty
a_8: assert property (p_8) else $error("a8");
cover property (v_q && res_o.skip);
cover property (v_q && o==0 && p_q.dest);
cover property (v_q ##1 v_q);
endmodule
bind fru_unary_ops fru_unary_ops_asserts u_chk (.mclk_i, .rst_i, .req_valid_i, .req_i, .res_o);

// File: tb/test_fru_unary_ops.sv
`timescale 1ns/1ps
module test_fru_unary_ops import fru_pkg::*;;
logic mclk_i = 0, rst_i = 1, req_valid_i = 0;
fru_req_s req_i = '0, q;
fru_res_s res_o, e0 = '0;
int fail_count = 0, n_tests = 0;
logic [31:0] s = 32'h0b7a;
// Free-running clock
always #4 mclk_i = ~mclk_i;
fru_unary_ops u_fru_unary_ops (.mclk_i, .rst_i, .req_valid_i, .req_i, .res_o);
function automatic logic [31:0] xs(logic [31:0] a); a ^= a << 13; a ^= a >> 17;
return a ^ (a << 5); endfunction
// Expected result of one request
function automatic fru_res_s ex(fru_req_s r);
logic [7:0] y = r.op==0 ? ~r.operand : r.op[0] ? r.operand-DATA_ONE : r.operand+DATA_ONE;
return {!r.dest, r.dest, r.addr, y, r.op<3, y==0, r.op>2 && y==0}; endfunction
task check(fru_res_s g, e); n_tests++; if (g !== e) begin fail_count++;
$display("BAD %0t got %h want %h", $time, g, e); end endtask
task summarize; $display("checks %0d bad %0d", n_tests, fail_count);
if (fail_count == 0 && n_tests > 0) $display("DONE - PASS"); else $display("DONE - FAIL");
$finish; endtask
// Corner operands 00 01 fe ff first, then random, back to back
initial begin
repeat (20) @(posedge mclk_i);
rst_i <= 0;
for (int i = 0; i < 302; i++) begin
@(posedge mclk_i);
s = xs(s);
q = fru_req_s'(s[16:0]);
q.op = fru_op_e'(i < 64 ? i % 5 : s % 5);
if (i < 64) begin q.operand = {{7{i[5]}}, i[4]}; q.dest = i[0]; end
req_valid_i <= i < 300;
req_i <= q;
// Settled mid-cycle: answer to the request driven one edge back
@(negedge mclk_i);
check(res_o, e0);
e0 = i < 300 ? ex(q) : fru_res_s'(0);
if (i == 63 || i == 301) $display("test %0d done", i);
end
summarize;
end
endmodule
